/* File: core/cstsel_consts.svh */
// Purpose: constants for the capture source select block
// Assumes: 16-bit register port, word index addressing
// Notes:   offsets are register indices
`ifndef CSTSEL_CONSTS_SVH
`define CSTSEL_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define CSTSEL_OFF_CTRL2   4'h0
`define CSTSEL_OFF_CTRL1   4'h1
`define CSTSEL_OFF_TIMER   4'h2
`define CSTSEL_OFF_IRQST   4'h3
`define CSTSEL_OFF_IRQEN   4'h4
`define CSTSEL_OFF_IRQCLR  4'h5

// ****************************************
// field positions and reset values
// ****************************************
`define CSTSEL_SEL_LSB     0
`define CSTSEL_SEL_MSB     4
`define CSTSEL_TRIG_BIT    5
`define CSTSEL_TSTAT_BIT   6
`define CSTSEL_CASC_BIT    8
`define CSTSEL_CTRL2_RST   16'h0000
`define CSTSEL_CTRL1_RST   16'h0000

// ****************************************
// source select codes
// ****************************************
`define CSTSEL_C_NONE0     5'h00
`define CSTSEL_C_OC1       5'h01
`define CSTSEL_C_OC8       5'h08
`define CSTSEL_C_NONE9     5'h09
`define CSTSEL_C_TGEN      5'h0a
`define CSTSEL_C_TMR1      5'h0b
`define CSTSEL_C_TMR5      5'h0f
`define CSTSEL_C_CAP1      5'h10
`define CSTSEL_C_CAP8      5'h17
`define CSTSEL_C_CMP1      5'h18
`define CSTSEL_C_CMP3      5'h1a
`define CSTSEL_C_ADC       5'h1b
`define CSTSEL_C_CHGT      5'h1c

// ****************************************
// interrupt status bits
// ****************************************
`define CSTSEL_IRQ_EVT     0
`define CSTSEL_IRQ_WRAP    1

`endif

/* File: core/cstsel_pkg.sv */
// Purpose: types for the capture source select block
// Assumes: nothing
// Notes:   constants live in cstsel_consts.svh
package cstsel_pkg;
    typedef logic [4:0]  cstsel_code_t;
    typedef logic [15:0] cstsel_word_t;
    typedef enum logic { CSTSEL_SYNC, CSTSEL_TRIG } cstsel_mode_e;
endpackage

/* File: core/cstsel_src_if.sv */
// Purpose: carries source events and code between top and mux
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ps
interface cstsel_src_if;
    cstsel_pkg::cstsel_code_t code;
    logic [7:0]               captureIrq;
    logic [7:0]               compareEvt;
    logic [4:0]               timerEvt;
    logic [2:0]               comparatorOut;
    logic                     adcIrq;
    logic                     chargeTimeTrig;
    logic                     triggerGenOut;
    logic                     selEvent;
    modport top (output code, captureIrq, compareEvt, timerEvt, comparatorOut,
                 adcIrq, chargeTimeTrig, triggerGenOut, input selEvent);
    modport mux (input code, captureIrq, compareEvt, timerEvt, comparatorOut,
                 adcIrq, chargeTimeTrig, triggerGenOut, output selEvent);
endinterface

/* File: core/cstsel_src_mux.sv */
// Purpose: picks the selected source event from the five-bit code
// Assumes: all event inputs are one-cycle pulses on core_clk
// Notes:   combinational
`timescale 1ns/1ps
`include "cstsel_consts.svh"
module cstsel_src_mux (
    // sources and result
    cstsel_src_if.mux src
);
    // ****************************************
    // selection
    // ****************************************
    logic [4:0] offs;
    always_comb begin
        offs = 5'h00;
        src.selEvent = 1'b0;
        if (src.code >= `CSTSEL_C_OC1 && src.code <= `CSTSEL_C_OC8) begin
            offs = src.code - `CSTSEL_C_OC1;
            src.selEvent = src.compareEvt[offs[2:0]];
        end else if (src.code == `CSTSEL_C_TGEN) begin
            src.selEvent = src.triggerGenOut;
        end else if (src.code >= `CSTSEL_C_TMR1 && src.code <= `CSTSEL_C_TMR5) begin
            offs = src.code - `CSTSEL_C_TMR1;
            src.selEvent = src.timerEvt[offs[2:0]];
        end else if (src.code >= `CSTSEL_C_CAP1 && src.code <= `CSTSEL_C_CAP8) begin
            offs = src.code - `CSTSEL_C_CAP1;
            src.selEvent = src.captureIrq[offs[2:0]];
        end else if (src.code >= `CSTSEL_C_CMP1 && src.code <= `CSTSEL_C_CMP3) begin
            offs = src.code - `CSTSEL_C_CMP1;
            src.selEvent = src.comparatorOut[offs[1:0]];
        end else if (src.code == `CSTSEL_C_ADC) begin
            src.selEvent = src.adcIrq;
        end else if (src.code == `CSTSEL_C_CHGT) begin
            src.selEvent = src.chargeTimeTrig;
        end else begin
            src.selEvent = 1'b0;
        end
    end
endmodule

/* File: core/cstsel_top.sv */
// Function
// - codes 11111, 11110, 11101, 01001, 00000 leave the timer unsynchronized
// - code 11100 selects the charge-time measurement trigger
// - code 11011 selects the first ADC interrupt
// - codes 11000 to 11010 select comparators 1 to 3
// - codes 10000 to 10111 select capture channel 1 to 8 interrupts
// - codes 01011 to 01111 select general-purpose timers 1 to 5
// - codes 00001 to 01000 select output compare 1 to 8
// - channel's trigger generator input: outputs 8..11 feed channels n and n+4
// - selected event sets trigger status; software reads, sets, clears it
// - select field sits in bits 4..0 of control two, for both modes
//
// Purpose: source select, status and capture timer of one capture channel
// Assumes: events are one-cycle pulses synchronous to core_clk
// Notes:   reads return data one cycle after the read strobe
`timescale 1ns/1ps
`include "cstsel_consts.svh"
module cstsel_top #(
    parameter int unsigned CHANNEL = 1
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // register port
    input  wire logic [3:0]                 regAddr,
    input  wire cstsel_pkg::cstsel_word_t   regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output cstsel_pkg::cstsel_word_t        regRdata,
    // source events
    input  wire logic [7:0]                 captureIrq,
    input  wire logic [7:0]                 compareEvt,
    input  wire logic [4:0]                 timerEvt,
    input  wire logic [2:0]                 comparatorOut,
    input  wire logic                       adcIrq,
    input  wire logic                       chargeTimeTrig,
    input  wire logic [3:0]                 triggerGenOut,
    // status outputs
    output cstsel_pkg::cstsel_word_t        captureTimer,
    output logic                            timerRunning,
    output logic                            cascadeEnable,
    output logic                            irq
);
    // ****************************************
    // registers
    // ****************************************
    cstsel_pkg::cstsel_code_t  syncSourceSelect;
    cstsel_pkg::cstsel_mode_e  mode;
    logic                      trigStatus;
    logic                      cascadeBit;
    logic [1:0]                irqStatus;
    logic [1:0]                irqEnable;
    logic                      tgenIn;
    logic                      selEvent;
    logic                      wrCtrl2;
    cstsel_src_if              src ();

    assign wrCtrl2 = regWr && regAddr == `CSTSEL_OFF_CTRL2;

    // ****************************************
    // trigger generator routing
    // ****************************************
    localparam int unsigned TGEN_IDX = (CHANNEL - 1) % 4;
    assign tgenIn = triggerGenOut[TGEN_IDX[1:0]];

    assign src.code           = syncSourceSelect;
    assign src.captureIrq     = captureIrq;
    assign src.compareEvt     = compareEvt;
    assign src.timerEvt       = timerEvt;
    assign src.comparatorOut  = comparatorOut;
    assign src.adcIrq         = adcIrq;
    assign src.chargeTimeTrig = chargeTimeTrig;
    assign src.triggerGenOut  = tgenIn;
    assign selEvent           = src.selEvent;

    cstsel_src_mux u_cstsel_src_mux (
        .src (src)
    );

    // ****************************************
    // control two: select, mode, status
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncSourceSelect <= 5'h00;
            mode             <= cstsel_pkg::CSTSEL_SYNC;
        end else if (wrCtrl2) begin
            syncSourceSelect <= regWdata[`CSTSEL_SEL_MSB:`CSTSEL_SEL_LSB];
            mode             <= cstsel_pkg::cstsel_mode_e'(regWdata[`CSTSEL_TRIG_BIT]);
        end
    end

    // event wins over software write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigStatus <= 1'b0;
        end else if (selEvent) begin
            trigStatus <= 1'b1;
        end else if (wrCtrl2) begin
            trigStatus <= regWdata[`CSTSEL_TSTAT_BIT];
        end
    end

    // ****************************************
    // control one: cascade
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cascadeBit <= 1'b0;
        end else if (regWr && regAddr == `CSTSEL_OFF_CTRL1) begin
            cascadeBit <= regWdata[`CSTSEL_CASC_BIT];
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cascadeEnable <= 1'b0;
        end else begin
            cascadeEnable <= cascadeBit;
        end
    end

    // ****************************************
    // capture timer
    // ****************************************
    logic wrap;
    assign wrap = timerRunning && captureTimer == 16'hffff;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            captureTimer <= 16'h0000;
            timerRunning <= 1'b0;
        end else if (wrCtrl2 && regWdata[`CSTSEL_TRIG_BIT]) begin
            captureTimer <= 16'h0000;
            timerRunning <= 1'b0;
        end else if (wrCtrl2) begin
            captureTimer <= 16'h0000;
            timerRunning <= 1'b1;
        end else if (mode == cstsel_pkg::CSTSEL_SYNC) begin
            captureTimer <= selEvent ? 16'h0000 : captureTimer + 16'h0001;
            timerRunning <= 1'b1;
        end else begin
            if (selEvent && !timerRunning) begin
                timerRunning <= 1'b1;
            end
            if (timerRunning) begin
                captureTimer <= captureTimer + 16'h0001;
            end
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    logic [1:0] irqEvents;
    assign irqEvents = {wrap, selEvent};
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatus <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (irqEvents[i]) begin
                    irqStatus[i] <= 1'b1;
                end else if (regWr && regAddr == `CSTSEL_OFF_IRQCLR && regWdata[i]) begin
                    irqStatus[i] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irqEnable <= 2'h0;
        end else if (regWr && regAddr == `CSTSEL_OFF_IRQEN) begin
            irqEnable <= regWdata[1:0];
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqEnable);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                `CSTSEL_OFF_CTRL2: regRdata <= {9'h000, trigStatus, mode, syncSourceSelect};
                `CSTSEL_OFF_CTRL1: regRdata <= {7'h00, cascadeBit, 8'h00};
                `CSTSEL_OFF_TIMER: regRdata <= captureTimer;
                `CSTSEL_OFF_IRQST: regRdata <= {14'h0000, irqStatus};
                `CSTSEL_OFF_IRQEN: regRdata <= {14'h0000, irqEnable};
                default:           regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end
endmodule

/* File: test/cstsel_monitor.sv */
// Purpose: property checks on the capture source select top
// Assumes: one clock, asynchronous active-low reset
// Notes:   shadows the select field, mode and interrupt enables
`timescale 1ns/1ps
module cstsel_monitor #(
    parameter int unsigned CHANNEL = 1
) (
    // clock, reset and register port
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    // source events
    input wire logic [7:0]  captureIrq,
    input wire logic [7:0]  compareEvt,
    input wire logic [4:0]  timerEvt,
    input wire logic [2:0]  comparatorOut,
    input wire logic        adcIrq,
    input wire logic        chargeTimeTrig,
    input wire logic [3:0]  triggerGenOut,
    // status
    input wire logic [15:0] captureTimer,
    input wire logic        timerRunning,
    input wire logic        irq
);
    logic [4:0]  codeSh;
    logic        modeSh;
    logic [1:0]  enSh;
    logic [31:0] srcVec;
    logic        selEvt;
    // ****************************************
    // register shadows and selected event
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            codeSh <= 5'h00;
            modeSh <= 1'b0;
            enSh   <= 2'h0;
        end else if (regWr && regAddr == 4'h0) begin
            codeSh <= regWdata[4:0];
            modeSh <= regWdata[5];
        end else if (regWr && regAddr == 4'h4) begin
            enSh <= regWdata[1:0];
        end
    end
    assign srcVec = {3'h0, chargeTimeTrig, adcIrq, comparatorOut, captureIrq, timerEvt,
                     triggerGenOut[(CHANNEL - 1) % 4], 1'b0, compareEvt, 1'b0};
    assign selEvt = srcVec[codeSh];
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    property p_evt_irq;
        selEvt && enSh[0] && !regWr ##1 enSh[0] && !regWr |=> irq;
    endproperty
    a_evt_irq: assert property (p_evt_irq) else $error("irq missing after event");
    property p_irq_mask;
        enSh == 2'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
    property p_sync_zero;
        !modeSh && selEvt && !regWr |=> captureTimer == 16'h0;
    endproperty
    a_sync_zero: assert property (p_sync_zero) else $error("sync event kept timer");
    property p_quiet;
        !modeSh && timerRunning && !selEvt && !regWr |=> captureTimer == $past(captureTimer) + 16'h1;
    endproperty
    a_quiet: assert property (p_quiet) else $error("timer disturbed");
    property p_trig_start;
        modeSh && !timerRunning && selEvt && !regWr |=> timerRunning;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
    property p_trig_hold;
        modeSh && !timerRunning && !selEvt && !regWr |=> !timerRunning && captureTimer == 16'h0;
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("timer ran untriggered");
    property p_rd_code;
        regRd && regAddr == 4'h0 |=> regRdata[5:0] == {$past(modeSh), $past(codeSh)};
    endproperty
    a_rd_code: assert property (p_rd_code) else $error("select field readback");
    property p_wr_zero;
        regWr && regAddr == 4'h0 |=> captureTimer == 16'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("timer not zeroed");
endmodule

bind cstsel_top cstsel_monitor #(.CHANNEL(CHANNEL)) u_cstsel_monitor (
    .core_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .captureIrq, .compareEvt,
    .timerEvt, .comparatorOut, .adcIrq, .chargeTimeTrig, .triggerGenOut, .captureTimer, .timerRunning, .irq
);

/* File: test/cstsel_evt_model.sv */
// Purpose: event sources around one capture channel
// Assumes: source index equals the select code
// Notes:   noise hits every source but the selected one
`timescale 1ns/1ps
module cstsel_evt_model #(
    parameter int unsigned CHANNEL = 1
) (
    // control
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [4:0]  code,
    input  wire logic        fire,
    input  wire logic [31:0] noise,
    // event pulses
    output logic [7:0]       captureIrq,
    output logic [7:0]       compareEvt,
    output logic [4:0]       timerEvt,
    output logic [2:0]       comparatorOut,
    output logic             adcIrq,
    output logic             chargeTimeTrig,
    output logic [3:0]       triggerGenOut
);
    logic [31:0] hit;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hit <= 32'h0;
        end else begin
            hit <= (noise & ~(32'h1 << code)) | ({31'h0, fire} << code);
        end
    end
    always_comb begin
        {chargeTimeTrig, adcIrq, comparatorOut, captureIrq, timerEvt} = hit[28:11];
        compareEvt = hit[8:1];
        triggerGenOut = {hit[31:29], hit[29]};
        triggerGenOut[(CHANNEL - 1) % 4] = hit[10];
    end
endmodule

/* File: test/cstsel_tb.sv */
// Purpose: self-checking bench for the capture source select top
// Assumes: register indices and field layout of the constants header
// Notes:   random noise on all unselected event sources
`timescale 1ns/1ps
module cstsel_tb;
    localparam int unsigned CH = 6;
    logic                     core_clk = 1'b0;
    logic                     arst_n = 1'b0;
    logic [3:0]               regAddr = 4'h0;
    logic [15:0]              regWdata = 16'h0000;
    logic                     regWr = 1'b0;
    logic                     regRd = 1'b0;
    logic [4:0]               code = 5'h00;
    logic                     fire = 1'b0;
    logic                     noiseOn = 1'b0;
    logic [31:0]              noise = 32'h0;
    int                       seed = 47;
    int                       badCount = 0;
    int                       nTests = 0;
    cstsel_pkg::cstsel_word_t regRdata;
    cstsel_pkg::cstsel_word_t captureTimer;
    logic                     timerRunning;
    logic                     cascadeEnable;
    logic                     irq;
    logic [7:0]               captureIrq;
    logic [7:0]               compareEvt;
    logic [4:0]               timerEvt;
    logic [2:0]               comparatorOut;
    logic                     adcIrq;
    logic                     chargeTimeTrig;
    logic [3:0]               triggerGenOut;

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) noise <= noiseOn ? $random(seed) : 32'h0;

    cstsel_top #(.CHANNEL(CH)) u_cstsel_top (.core_clk, .arst_n, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .captureIrq, .compareEvt, .timerEvt, .comparatorOut, .adcIrq, .chargeTimeTrig,
        .triggerGenOut, .captureTimer, .timerRunning, .cascadeEnable, .irq);
    cstsel_evt_model #(.CHANNEL(CH)) u_cstsel_evt_model (.core_clk, .arst_n, .code, .fire, .noise,
        .captureIrq, .compareEvt, .timerEvt, .comparatorOut, .adcIrq, .chargeTimeTrig, .triggerGenOut);

    // ****************************************
    // bus, compare and closing tasks
    // ****************************************
    task automatic closeOut;
        $display("checks %0d errors %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        chk(regRdata, e);
    endtask
    task automatic pulse;
        @(posedge core_clk);
        fire <= 1'b1;
        @(posedge core_clk);
        fire <= 1'b0;
    endtask
    // sel: 0 irq, 1 cascade enable, 2 timer running; sampled after the wait
    task automatic bitIs(input int unsigned sel, input logic e);
        logic b;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        b = (sel == 0) ? irq : ((sel == 1) ? cascadeEnable : timerRunning);
        chk({15'h0, b}, {15'h0, e});
    endtask
    function automatic logic expSel(input logic [4:0] c);
        return (c >= 5'h01 && c <= 5'h08) || (c >= 5'h0a && c <= 5'h1c);
    endfunction

    initial begin
        #100000;
        badCount++;
        closeOut();
    end
    initial begin
        logic [4:0] c;
        logic       m;
        logic       st;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rc(4'h0, 16'h0000);
        rc(4'h1, 16'h0000);
        for (int i = 0; i < 32; i++) begin
            c  = 5'(i);
            m  = (c >= 5'h18 && c <= 5'h1b);
            st = expSel(c);
            if (c == 5'(15 + CH)) continue;
            @(posedge core_clk);
            noiseOn <= 1'b0;
            code    <= c;
            repeat (3) @(posedge core_clk);
            wr(4'h0, {10'h0, m, c});
            wr(4'h5, 16'h0003);
            noiseOn <= 1'b1;
            repeat (8) @(posedge core_clk);
            rc(4'h0, {10'h0, m, c});
            pulse();
            rc(4'h0, {9'h0, st, m, c});
            rc(4'h3, {15'h0, st});
        end
        @(posedge core_clk);
        code <= 5'h0b;
        wr(4'h0, 16'h004b);
        rc(4'h0, 16'h004b);
        wr(4'h5, 16'h0003);
        wr(4'h4, 16'h0001);
        pulse();
        bitIs(0, 1'b1);
        wr(4'h4, 16'h0000);
        bitIs(0, 1'b0);
        wr(4'h4, 16'h0001);
        bitIs(0, 1'b1);
        wr(4'h5, 16'h0001);
        bitIs(0, 1'b0);
        rc(4'h3, 16'h0000);
        rc(4'h5, 16'h0000);
        rc(4'hf, 16'h0000);
        wr(4'h0, 16'h002b);
        repeat (4) @(posedge core_clk);
        rc(4'h2, 16'h0000);
        bitIs(2, 1'b0);
        pulse();
        bitIs(2, 1'b1);
        wr(4'h1, 16'h0100);
        bitIs(1, 1'b1);
        rc(4'h1, 16'h0100);
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rc(4'h0, 16'h0000);
        closeOut();
    end
endmodule
